//--- include/pcb_pkg.sv
// Purpose: Shared constants and carriers for the bridge configuration header block
// Assumes: Configuration accesses arrive as decoded dword requests on the primary clock
// Notes:   Offsets are byte addresses; all are dword aligned
package pcb_pkg;

    // Register byte offsets within configuration space
    localparam logic [7:0]  PCB_OFF_CMD_STATUS  = 8'h04;  // Command low half, status high half
    localparam logic [7:0]  PCB_OFF_REV_CLASS   = 8'h08;  // Revision and class dword
    localparam logic [7:0]  PCB_OFF_CLS_LAT_HDR = 8'h0c;  // Line size, latency, header type
    localparam logic [7:0]  PCB_OFF_BUS_NUMBERS = 8'h18;  // Upstream bus number dword

    // Command field positions and writable bits (io, mem, master, palette, parity, fault, fbb)
    localparam int          PCB_CMD_PARITY_RESP = 6;
    localparam int          PCB_CMD_FAULT_EN    = 8;
    localparam logic [15:0] PCB_CMD_WMASK       = 16'h0367;

    // Status half-word layout: bit n here is dword bit n+16
    localparam int          PCB_ST_DATA_PERR    = 8;      // Data parity error detected
    localparam int          PCB_ST_SIG_TABORT   = 11;     // Signaled target abort
    localparam int          PCB_ST_RCV_TABORT   = 12;     // Received target abort
    localparam int          PCB_ST_RCV_MABORT   = 13;     // Received master abort
    localparam int          PCB_ST_SIG_SYSERR   = 14;     // Signaled system error
    localparam int          PCB_ST_DET_PERR     = 15;     // Detected parity error
    localparam logic [15:0] PCB_ST_W1C_MASK     = 16'hf900;
    localparam logic [15:0] PCB_ST_FIXED        = 16'h02b0; // Caps list, 66 MHz, fbb, medium select

    // Hardwired identity bytes
    localparam logic [7:0]  PCB_PROG_IF         = 8'h00;
    localparam logic [7:0]  PCB_SUB_CLASS       = 8'h04;
    localparam logic [7:0]  PCB_BASE_CLASS      = 8'h06;
    localparam logic [7:0]  PCB_HEADER_TYPE     = 8'h01;
    localparam logic [7:0]  PCB_CLS_MAX         = 8'h10;  // Largest valid line size in dwords
    localparam logic [4:0]  PCB_PREFETCH_MIN    = 5'h01;  // Dwords fetched with no valid line size

    // Configuration request from the primary target decoder
    typedef struct packed {
        logic        rd;     // One-cycle read strobe
        logic        wr;     // One-cycle write strobe
        logic [7:0]  addr;   // Byte offset, low two bits ignored
        logic [3:0]  be;     // Byte enables, active high
        logic [31:0] wdata;  // Write data
    } pcb_cfg_req_t;

    // Configuration read answer
    typedef struct packed {
        logic        valid;  // One-cycle answer strobe
        logic [31:0] data;   // Read data
    } pcb_cfg_rsp_t;

    // Error events from primary master and target logic, one-cycle pulses
    typedef struct packed {
        logic targetAbortSent;   // We ended a cycle with target abort
        logic targetAbortSeen;   // Our mastered cycle got target abort
        logic masterAbortSeen;   // Our mastered cycle was never claimed
        logic parityErrorSeen;   // Address or data parity error detected
        logic systemFaultReq;    // Logic wants the system fault pin
    } pcb_events_t;

    // Primary master activity used by timer and line logic
    typedef struct packed {
        logic       frameStart;  // Pulse when we assert the frame signal
        logic       frameActive; // Level while our transaction runs
        logic       mwiActive;   // Write-and-invalidate in progress
        logic [7:0] dwordIndex;  // Dword address of the current data phase
    } pcb_master_t;

endpackage : pcb_pkg

//--- hw/pcb_pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for an active-low pin
// Assumes: Pin idles high
// Notes:   Output is high while the pin is seen asserted
module pcb_pin_sync
    import pcb_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Pin and result
    input  wire logic pinN,
    output logic      asserted
);

    typedef struct packed {
        logic s1;       // Metastability catcher, read by s2 only
        logic s2;
        logic s3;
        logic level;    // Filtered asserted level
    } pcb_sync_t;

    pcb_sync_t st_reg;
    pcb_sync_t st_next;

    // Level moves only once the second and third stage agree
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = pinN;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        if (st_reg.s2 == st_reg.s3) begin
            st_next.level = ~st_reg.s2;
        end
    end

    // State register, idle pin reads high
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, level: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign asserted = st_reg.level;

endmodule : pcb_pin_sync

//--- hw/pcb_latency_timer.sv
// Purpose: Master latency counter for the primary interface
// Assumes: Start pulse coincides with our frame assertion
// Notes:   A zero setting expires one edge after the edge that takes the frame start
module pcb_latency_timer
    import pcb_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Control
    input  wire logic [7:0] loadValue,
    input  wire logic       frameStart,
    input  wire logic       frameActive,
    // Result
    output logic            expired
);

    typedef struct packed {
        logic [7:0] count;    // Clocks left
        logic       running;  // Timer armed for this frame
        logic       expired;  // Timer ran out
    } pcb_timer_t;

    pcb_timer_t st_reg;
    pcb_timer_t st_next;

    // Load on frame start, count down while our frame is on the bus
    always_comb begin
        st_next = st_reg;
        if (frameStart) begin
            st_next.count   = loadValue;
            st_next.running = 1'b1;
            st_next.expired = 1'b0;
        end else if (!frameActive) begin
            st_next.running = 1'b0;
            st_next.expired = 1'b0;
        end else if (st_reg.running) begin
            if (st_reg.count != 8'h00) begin
                st_next.count = st_reg.count - 8'h01;
            end else begin
                st_next.expired = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign expired = st_reg.expired;

endmodule : pcb_latency_timer

//--- hw/pcb_config_header.sv
// Purpose: Primary-side configuration header registers of a bridge
// Assumes: Target decoder delivers one-cycle config strobes on the primary clock
// Notes:   Reads answer one clock after the strobe; outputs are all registered except the fault pin level, which is tied low
//
// Summary of operation
// - Capabilities list status bit reads one
// - 66 MHz capable status bit reads one
// - Fast back-to-back capable bit reads one
// - Parity pin with response enabled sets flag
// - Device select timing field reports medium
// - Our target abort sets signaled-abort flag
// - Received target abort sets its flag
// - Unclaimed mastered cycle sets master-abort flag
// - Driving system fault pin sets flag
// - Any detected parity error sets flag
// - Hardwired revision byte in low byte
// - Class code reads bridge, PCI bridge
// - Line size register read-write, resets zero
// - Latency byte loads master latency counter
// - Header type byte reads bridge layout
// - Upstream bus number read-write, resets zero
// - Command parity response bit, reset zero
// - Fault pin driven only when enabled
module pcb_config_header
    import pcb_pkg::*;
#(
    // Arbitrary neutral value, not any real part's revision
    parameter logic [7:0] REVISION_IDENTIFIER = 8'h5a
)
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // Configuration access
    input  wire pcb_cfg_req_t cfgReq,
    output pcb_cfg_rsp_t      cfgRsp,
    // Error events from primary master and target logic
    input  wire pcb_events_t  events,
    // Primary master activity
    input  wire pcb_master_t  master,
    // Upstream parity fault pin, observed only
    input  wire logic         upstreamParityFaultPinN,
    // Upstream system fault pin, open drain
    output logic              upstreamSystemFaultPinOutN,
    output logic              upstreamSystemFaultPinOe,
    // Settings used by the bridge datapath
    output logic [15:0]       commandBits,
    output logic [7:0]        upstreamBusNumber,
    output logic              latencyExpired,
    output logic              mwiLineEnd,
    output logic [4:0]        prefetchDwords
);

    // Whole state of the header in one record
    typedef struct packed {
        logic [15:0]  command;      // Command register
        logic [15:0]  statusFlags;  // Sticky error flags, status layout
        logic [7:0]   cacheLine;    // Line size in dwords
        logic [7:0]   latency;      // Master latency setting
        logic [7:0]   busNumber;    // Upstream bus number
        pcb_cfg_rsp_t rsp;          // Read answer
        logic         faultDrive;   // Pulling the fault pin low
        logic         lineEnd;      // Next data phase closes a line
        logic [4:0]   prefetch;     // Dwords to fetch ahead
    } pcb_state_t;

    localparam pcb_state_t PCB_STATE_RESET = '{
        command:     16'h0000,
        statusFlags: 16'h0000,
        cacheLine:   8'h00,
        latency:     8'h00,
        busNumber:   8'h00,
        rsp:         '{valid: 1'b0, data: 32'h0000_0000},
        faultDrive:  1'b0,
        lineEnd:     1'b0,
        prefetch:    5'h01
    };

    pcb_state_t st_reg;           // Registered state
    pcb_state_t st_next;          // Next state

    logic [31:0] laneMask;        // Byte enables spread to bits
    logic        parityPinSeen;   // Filtered parity pin level
    logic        lineSizeValid;   // Line size is zero or a legal power of two
    logic        lineSizeUsable;  // Valid and nonzero
    logic [7:0]  lineMaskBits;    // Dword offset mask within a line

    // Parity pin comes from the bus, so it is synchronised first
    pcb_pin_sync u_parity_sync (
        .clk      (clk),
        .resetn   (resetn),
        .pinN     (upstreamParityFaultPinN),
        .asserted (parityPinSeen)
    );

    // Latency counter for frames we master
    pcb_latency_timer u_latency (
        .clk         (clk),
        .resetn      (resetn),
        .loadValue   (st_reg.latency),
        .frameStart  (master.frameStart),
        .frameActive (master.frameActive),
        .expired     (latencyExpired)
    );

    // One byte lane per enable bit
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++) begin : g_lane
            assign laneMask[lane*8 +: 8] = {8{cfgReq.be[lane]}};
        end
    endgenerate

    // Line size check: one bit set at most, and no larger than the maximum
    always_comb begin
        lineSizeValid  = ((st_reg.cacheLine & (st_reg.cacheLine - 8'h01)) == 8'h00)
                         && (st_reg.cacheLine <= PCB_CLS_MAX);
        lineSizeUsable = lineSizeValid && (st_reg.cacheLine != 8'h00);
        lineMaskBits   = st_reg.cacheLine - 8'h01;
    end

    // Next-state logic: writes, sticky flags, read answer and datapath settings
    always_comb begin
        logic [31:0] wbits;       // Bits this write may touch
        logic [15:0] flagSet;     // Events arriving this cycle
        logic [15:0] flagClr;     // Write-one clears this cycle
        logic        hitCmd;      // Write to command and status
        logic        hitLine;     // Write to line size dword
        logic        hitBus;      // Write to bus number dword

        wbits   = cfgReq.wr ? laneMask : 32'h0000_0000;
        flagSet = 16'h0000;
        flagClr = 16'h0000;
        hitCmd  = cfgReq.wr && (cfgReq.addr[7:2] == PCB_OFF_CMD_STATUS[7:2]);
        hitLine = cfgReq.wr && (cfgReq.addr[7:2] == PCB_OFF_CLS_LAT_HDR[7:2]);
        hitBus  = cfgReq.wr && (cfgReq.addr[7:2] == PCB_OFF_BUS_NUMBERS[7:2]);
        st_next = st_reg;

        // Command writes touch only the implemented bits
        if (hitCmd) begin
            st_next.command = (st_reg.command & ~(wbits[15:0] & PCB_CMD_WMASK))
                            | (cfgReq.wdata[15:0] & wbits[15:0] & PCB_CMD_WMASK);
            flagClr = cfgReq.wdata[31:16] & wbits[31:16] & PCB_ST_W1C_MASK;
        end

        // Line size and latency bytes; header type byte stays fixed
        if (hitLine) begin
            if (wbits[0]) begin
                // Illegal sizes are stored as written; the datapath ignores them
                st_next.cacheLine = cfgReq.wdata[7:0];
            end
            if (wbits[8]) begin
                st_next.latency = cfgReq.wdata[15:8];
            end
        end

        // Upstream bus number byte; the rest of the dword is not held here
        if (hitBus && wbits[0]) begin
            st_next.busNumber = cfgReq.wdata[7:0];
        end

        // Parity pin counts only with parity response enabled
        flagSet[PCB_ST_DATA_PERR] = parityPinSeen
                                    && st_reg.command[PCB_CMD_PARITY_RESP];
        flagSet[PCB_ST_SIG_TABORT] = events.targetAbortSent;
        flagSet[PCB_ST_RCV_TABORT] = events.targetAbortSeen;
        flagSet[PCB_ST_RCV_MABORT] = events.masterAbortSeen;
        // Flag follows the clock in which the pin is actually pulled
        flagSet[PCB_ST_SIG_SYSERR] = st_reg.faultDrive;
        // Detection is recorded whatever the response setting says
        flagSet[PCB_ST_DET_PERR]   = events.parityErrorSeen;

        // Set wins over a clear in the same clock
        st_next.statusFlags = (st_reg.statusFlags & ~flagClr) | flagSet;

        // Fault pin is pulled for one clock per request, only when enabled
        st_next.faultDrive = events.systemFaultReq
                             && st_reg.command[PCB_CMD_FAULT_EN];

        // Write-and-invalidate stops on a line boundary when the size is legal
        st_next.lineEnd = master.mwiActive && lineSizeUsable
                          && ((master.dwordIndex & lineMaskBits) == lineMaskBits);
        // Prefetch a whole line, or a single dword when no usable size is set
        st_next.prefetch = lineSizeUsable ? st_reg.cacheLine[4:0]
                                          : PCB_PREFETCH_MIN;

        // Read answer one clock after the strobe; unmapped dwords read zero
        st_next.rsp.valid = cfgReq.rd;
        st_next.rsp.data  = 32'h0000_0000;
        if (cfgReq.rd) begin
            case (cfgReq.addr[7:2])
                PCB_OFF_CMD_STATUS[7:2]: begin
                    // Fixed capability bits and medium timing are ORed in
                    st_next.rsp.data = {st_reg.statusFlags | PCB_ST_FIXED,
                                        st_reg.command};
                end
                PCB_OFF_REV_CLASS[7:2]: begin
                    st_next.rsp.data = {PCB_BASE_CLASS, PCB_SUB_CLASS,
                                        PCB_PROG_IF, REVISION_IDENTIFIER};
                end
                PCB_OFF_CLS_LAT_HDR[7:2]: begin
                    st_next.rsp.data = {8'h00, PCB_HEADER_TYPE,
                                        st_reg.latency, st_reg.cacheLine};
                end
                PCB_OFF_BUS_NUMBERS[7:2]: begin
                    st_next.rsp.data = {24'h00_0000, st_reg.busNumber};
                end
                default: begin
                    st_next.rsp.data = 32'h0000_0000;
                end
            endcase
        end
    end

    // State register; reset gives constants only
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= PCB_STATE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register
    assign cfgRsp                     = st_reg.rsp;
    assign commandBits                = st_reg.command;
    assign upstreamBusNumber          = st_reg.busNumber;
    assign mwiLineEnd                 = st_reg.lineEnd;
    assign prefetchDwords             = st_reg.prefetch;
    // Open drain: only ever pulls low, enable marks the drive
    assign upstreamSystemFaultPinOutN = 1'b0;
    assign upstreamSystemFaultPinOe   = st_reg.faultDrive;

endmodule : pcb_config_header

//--- bench/pcb_config_header_props.sv
// Purpose: Port-level checks of the bridge configuration header
// Assumes: Single primary clock, reset active low
// Notes:   Read checks skip cycles where a write lands together with the read
module pcb_config_header_props
    import pcb_pkg::*;
#(
    parameter logic [7:0] REVISION_IDENTIFIER = 8'h5a
)
(
    // Clock and reset
    input wire logic         clk,
    input wire logic         resetn,
    // Configuration access
    input wire pcb_cfg_req_t cfgReq,
    input wire pcb_cfg_rsp_t cfgRsp,
    // Events and master activity
    input wire pcb_events_t  events,
    input wire pcb_master_t  master,
    input wire logic         upstreamParityFaultPinN,
    // Fault pin and settings
    input wire logic         upstreamSystemFaultPinOutN,
    input wire logic         upstreamSystemFaultPinOe,
    input wire logic [15:0]  commandBits,
    input wire logic [7:0]   upstreamBusNumber,
    input wire logic         latencyExpired,
    input wire logic         mwiLineEnd,
    input wire logic [4:0]   prefetchDwords
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    logic [5:0] dw;     // Dword index of the request
    logic       rdOnly; // Read without a write in the same cycle
    assign dw = cfgReq.addr[7:2];
    assign rdOnly = cfgReq.rd && !cfgReq.wr;

    a_caps_bits: assert property (rdOnly && dw == 6'h01 |=>
        cfgRsp.valid && cfgRsp.data[23:20] == 4'hb) else $error("status capability bits wrong");
    a_select_timing: assert property (rdOnly && dw == 6'h01 |=>
        cfgRsp.data[26:25] == 2'b01) else $error("select timing field wrong");
    a_command_echo: assert property (rdOnly && dw == 6'h01 |=>
        cfgRsp.data[15:0] == commandBits) else $error("command half differs");
    a_class_ident: assert property (rdOnly && dw == 6'h02 |=>
        cfgRsp.data == {24'h060400, REVISION_IDENTIFIER}) else $error("class dword wrong");
    a_header_ident: assert property (rdOnly && dw == 6'h03 |=>
        cfgRsp.data[31:16] == 16'h0001) else $error("header type wrong");
    a_bus_echo: assert property (rdOnly && dw == 6'h06 |=>
        cfgRsp.data == {24'h0, upstreamBusNumber}) else $error("bus number read wrong");
    a_fault_drive: assert property (events.systemFaultReq && commandBits[8] |=>
        upstreamSystemFaultPinOe && !upstreamSystemFaultPinOutN)
        else $error("fault pin not driven");
    a_fault_gate: assert property (upstreamSystemFaultPinOe |->
        $past(events.systemFaultReq && commandBits[8])) else $error("fault pin driven unasked");
    a_timer_clear: assert property (!master.frameActive |=> !latencyExpired)
        else $error("expiry outlived frame");
    a_line_idle: assert property (!master.mwiActive |=> !mwiLineEnd)
        else $error("line end without write-invalidate");

    // Main scenarios reached
    c_fault: cover property (upstreamSystemFaultPinOe);
    c_expired: cover property (latencyExpired);
    c_line: cover property (mwiLineEnd);
endmodule : pcb_config_header_props

bind pcb_config_header pcb_config_header_props #(.REVISION_IDENTIFIER(REVISION_IDENTIFIER)) i_props (
    .clk(clk), .resetn(resetn), .cfgReq(cfgReq), .cfgRsp(cfgRsp), .events(events),
    .master(master), .upstreamParityFaultPinN(upstreamParityFaultPinN),
    .upstreamSystemFaultPinOutN(upstreamSystemFaultPinOutN),
    .upstreamSystemFaultPinOe(upstreamSystemFaultPinOe), .commandBits(commandBits),
    .upstreamBusNumber(upstreamBusNumber), .latencyExpired(latencyExpired),
    .mwiLineEnd(mwiLineEnd), .prefetchDwords(prefetchDwords));

//--- bench/pcb_host_model.sv
// Purpose: Configuration host on the primary bus, plus the shared parity pin
// Assumes: Requests launch just after a rising edge
// Notes:   Pin is pulled up, so a release reads high
module pcb_host_model
    import pcb_pkg::*;
(
    // Clock
    input  wire logic         clk,
    // Configuration bus
    output pcb_cfg_req_t      cfgReq,
    input  wire pcb_cfg_rsp_t cfgRsp,
    // Parity fault pin
    output logic              parityPinN
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        cfgReq = '0;
        parityPinN = 1'b1;
    end

    // One-cycle write strobe; software picks legal sizes and W1C masks
    task cfgWrite(input logic [7:0] a, input logic [3:0] be,
                  input logic [31:0] d);
        @(posedge clk);
        #1 cfgReq = '{rd: 1'b0, wr: 1'b1, addr: a, be: be, wdata: d};
        @(posedge clk);
        #1 cfgReq = '0;
    endtask : cfgWrite

    // Answer stands for the one cycle after the taking edge, so it is sampled then
    task cfgRead(input logic [7:0] a, output logic [31:0] d, output logic ok);
        @(posedge clk);
        #1 cfgReq = '{rd: 1'b1, wr: 1'b0, addr: a, be: 4'h0, wdata: 32'h0};
        @(posedge clk);
        #1 cfgReq = '0;
        ok = cfgRsp.valid;
        d = cfgRsp.data;
    endtask : cfgRead

    // Pull the pin low for n cycles
    task parityFault(input int n);
        @(posedge clk);
        #1 parityPinN = 1'b0;
        repeat (n) @(posedge clk);
        #1 parityPinN = 1'b1;
    endtask : parityFault
endmodule : pcb_host_model

//--- bench/tb.sv
// Purpose: Self-checking bench of the bridge configuration header
// Assumes: 10 MHz clock, reset held five cycles
// Notes:   Events stand in for the primary master and target logic
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, a, b); end end
module tb
    import pcb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] REV = 8'h5a; // Arbitrary value

    logic         clk, resetn, perrN, oe, outN, expired, lineEnd, oeSeen;
    pcb_cfg_req_t cfgReq;
    pcb_cfg_rsp_t cfgRsp;
    pcb_events_t  events;
    pcb_master_t  master;
    logic [15:0]  cmd;
    logic [7:0]   busNum;
    logic [4:0]   prefetch, evBits;
    logic [31:0]  rdata;
    int           num_errors, n_checks;

    pcb_config_header #(.REVISION_IDENTIFIER(REV)) i_dut (.clk(clk), .resetn(resetn),
        .cfgReq(cfgReq), .cfgRsp(cfgRsp), .events(events), .master(master),
        .upstreamParityFaultPinN(perrN), .upstreamSystemFaultPinOutN(outN),
        .upstreamSystemFaultPinOe(oe), .commandBits(cmd), .upstreamBusNumber(busNum),
        .latencyExpired(expired), .mwiLineEnd(lineEnd), .prefetchDwords(prefetch));
    pcb_host_model i_host (.clk(clk), .cfgReq(cfgReq), .cfgRsp(cfgRsp), .parityPinN(perrN));

    // Read a dword and compare it whole
    task rdChk(input logic [7:0] a, input logic [31:0] exp);
        logic ok;
        i_host.cfgRead(a, rdata, ok);
        `CHK(ok, 1'b1)
        `CHK(rdata, exp)
    endtask : rdChk

    // One-cycle event pulse; pin drive seen one cycle later
    task pulse(input pcb_events_t ev);
        @(posedge clk);
        #1 events = ev;
        @(posedge clk);
        #1 oeSeen = oe;
        events = '0;
    endtask : pulse

    task testReset;
        rdChk(8'h04, 32'h02b00000);
        rdChk(8'h08, {24'h060400, REV});
        rdChk(8'h0c, 32'h00010000);
        rdChk(8'h18, 32'h0);
        `CHK(prefetch, 5'h01)
    endtask : testReset

    // Read-only bytes and unmapped places must ignore writes
    task testWrites;
        i_host.cfgWrite(8'h0c, 4'hf, 32'hffff2008);
        rdChk(8'h0c, 32'h00012008);
        i_host.cfgWrite(8'h18, 4'hf, 32'hffffff5a);
        i_host.cfgWrite(8'h1c, 4'hf, 32'hffffffff);
        rdChk(8'h18, 32'h0000005a);
        rdChk(8'h1c, 32'h0);
        i_host.cfgWrite(8'h08, 4'hf, 32'h0);
        rdChk(8'h08, {24'h060400, REV});
        i_host.cfgWrite(8'h04, 4'hf, 32'hffffffff);
        rdChk(8'h04, 32'h02b00367);
    endtask : testWrites

    task testFlags;
        for (int i = 0; i < 4; i++) begin
            evBits = 5'b10000 >> i;
            pulse(evBits);
            rdChk(8'h04,
                  32'h02b00367 | (32'h1 << ((i == 3) ? 31 : 27 + i)));
            i_host.cfgWrite(8'h04, 4'b1000, 32'hff000000);
        end
        pulse(5'b10000);
        i_host.cfgWrite(8'h04, 4'b1100, 32'h0);
        rdChk(8'h04, 32'h0ab00367);
        // Clear and new event in the same cycle: the event must win
        fork
            i_host.cfgWrite(8'h04, 4'b1000, 32'hff000000);
            pulse(5'b10000);
        join
        rdChk(8'h04, 32'h0ab00367);
        i_host.cfgWrite(8'h04, 4'b1000, 32'hff000000);
    endtask : testFlags

    // Fault pin and parity pin, each with its enable on and off
    task testPins;
        pulse(5'b00001);
        `CHK(oeSeen, 1'b1)
        rdChk(8'h04, 32'h42b00367);
        i_host.cfgWrite(8'h04, 4'b1011, 32'hff000000);
        pulse(5'b00001);
        `CHK(oeSeen, 1'b0)
        i_host.parityFault(4);
        repeat (6) @(posedge clk);
        rdChk(8'h04, 32'h02b00000);
        i_host.cfgWrite(8'h04, 4'b0011, 32'h00000040);
        i_host.parityFault(4);
        repeat (6) @(posedge clk);
        rdChk(8'h04, 32'h03b00040);
    endtask : testPins

    // Latency 2 expires N+1 edges after the edge that takes the frame start
    task testTimer;
        i_host.cfgWrite(8'h0c, 4'b0010, 32'h00000200);
        @(posedge clk);
        #1 master.frameStart = 1'b1;
        master.frameActive = 1'b1;
        @(posedge clk);
        #1 master.frameStart = 1'b0;
        repeat (2) @(posedge clk);
        #1 `CHK(expired, 1'b0)
        @(posedge clk);
        #1 `CHK(expired, 1'b1)
        master.frameActive = 1'b0;
        @(posedge clk);
        #1 `CHK(expired, 1'b0)
    endtask : testTimer

    // Line end and prefetch follow a legal size; a zero size acts as none
    task testLine;
        i_host.cfgWrite(8'h0c, 4'b0001, 32'h00000004);
        master.mwiActive = 1'b1;
        master.dwordIndex = 8'h07;
        @(posedge clk);
        #1 `CHK({lineEnd, prefetch}, 6'h24)
        master.dwordIndex = 8'h06;
        @(posedge clk);
        #1 `CHK(lineEnd, 1'b0)
        i_host.cfgWrite(8'h0c, 4'b0001, 32'h00000000);
        master.dwordIndex = 8'h07;
        @(posedge clk);
        #1 `CHK({lineEnd, prefetch}, 6'h01)
    endtask : testLine

    task final_report;
        if (num_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        resetn = 1'b0;
        events = '0;
        master = '0;
        repeat (5) @(posedge clk);
        #1 resetn = 1'b1;
        testReset;
        testWrites;
        testFlags;
        testPins;
        testTimer;
        testLine;
        final_report;
    end

    // Whole run needs about 120 cycles
    initial begin
        #500000;
        num_errors++;
        final_report;
    end
endmodule : tb
